// File: logic/msd_map.svh
// register offsets, field positions, reset values and timing counts of the decoder
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
`define MSD_OFF_PAGE 8'hE0
`define MSD_OFF_SPACE 8'hC2
`define MSD_OFF_PWR0 8'hB0
`define MSD_OFF_PWR2 8'hB4
`define MSD_RST_PAGE 8'h00
`define MSD_RST_SPACE 8'h0C
`define MSD_RST_PWR0 8'h08
`define MSD_RST_PWR2 8'h00
`define MSD_BIT_PIO 7
`define MSD_BIT_RD_PRI 4
`define MSD_BIT_RD_SEC 3
`define MSD_BIT_PS_PRI 2
`define MSD_BIT_PS_SEC 1
`define MSD_BIT_PS_RAM 0
`define MSD_BIT_TURBO 3
`define MSD_IDLE_NS 70
`define MSD_CLK_NS 10
`define MSD_IDLE_CYC ((`MSD_IDLE_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)
`define MSD_WIN_BASE 16'hFF00
`define MSD_WIN_MASK 16'hFF00
`endif

// File: logic/msd_pkg.sv
// types shared by the memory-space decoder
package msd_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic fetch_n;
        logic rd_n;
        logic wr_n;
        logic ale;
    } msd_bus_s;
    typedef struct packed {
        logic [7:0] primary;
        logic [3:0] secondary;
        logic ram;
        logic regs;
        logic [1:0] periph;
    } msd_sel_s;
    typedef enum logic [0:0] {
        MSD_ACTIVE = 1'b0,
        MSD_STANDBY = 1'b1
    } msd_pwr_e;
endpackage

// File: logic/msd_term.sv
// one programmable select built from a few masked-compare product terms
`timescale 1ns/1ns
module msd_term #(
    parameter int IN_W = 40,
    parameter int TERMS = 3
) (
    // decode inputs
    input wire logic [IN_W-1:0] vec,
    // programmed terms
    input wire logic [TERMS*IN_W-1:0] care,
    input wire logic [TERMS*IN_W-1:0] match,
    input wire logic [TERMS-1:0] term_en,
    // result
    output logic hit
);
    if (TERMS < 1 || IN_W < 1) begin : g_bad_size
        $error("msd_term: bad size");
    end
    always_comb begin
        hit = 1'b0;
        for (int t = 0; t < TERMS; t++) begin
            if (term_en[t] && (((vec ^ match[t*IN_W +: IN_W]) & care[t*IN_W +: IN_W]) == '0)) begin
                hit = 1'b1;
            end
        end
    end
endmodule

// File: logic/msd_idle.sv
// standby detector: flags when decode inputs sat unchanged long enough
`timescale 1ns/1ns
`include "msd_map.svh"
module msd_idle #(
    parameter int IN_W = 40,
    parameter int CYC = `MSD_IDLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // inputs
    input wire logic [IN_W-1:0] vec,
    input wire logic allow,
    // state
    output msd_pkg::msd_pwr_e state
);
    logic [IN_W-1:0] last_q;
    logic [7:0] cnt_q;
    // the idle counter is eight bits wide
    if (CYC < 1 || CYC > 255) begin : g_bad_count
        $error("msd_idle: bad count");
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_q <= '0;
        end else begin
            last_q <= vec;
        end
    end
    // see R16
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            state <= msd_pkg::MSD_ACTIVE;
        end else if (!allow || vec != last_q) begin
            cnt_q <= 8'h00;
            state <= msd_pkg::MSD_ACTIVE;
        end else if (cnt_q >= 8'(CYC - 1)) begin
            state <= msd_pkg::MSD_STANDBY;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// File: logic/msd_decode.sv
// memory-space decoder: page and mapping registers, decode array, priorities
`timescale 1ns/1ns
`include "msd_map.svh"
// Operation
// R1: mapping bits 4..0 permit read/fetch strobes to primary, secondary flash and SRAM
// R2: read strobe never selects secondary flash while mapping bit 3 is clear
// R3: mapping bit 7 enables peripheral I/O mode; bits 6 and 5 do nothing
// R4: software loads 0Ch into mapping for separate program and data spaces
// R5: bits 2 and 4 together put primary flash in combined space
// R6: eight-bit page register written from data bits 0..7 and read back
// R7: page register sits at register block offset E0h
// R8: page bits feed the decode array for every flash and SRAM select
// R9: page bits are also exported to the general logic array
// R10: decode inputs: address, four strobes, reset, power-down, ports, page, feedback, ready
// R11: eight primary sector selects, up to three product terms each; each third term is also the next select's first term
// R12: four secondary sector selects, up to three product terms each; each third term is also the next select's first term
// R13: one SRAM select from up to two product terms
// R14: one register block select and two peripheral selects
// R15: register block select drives whenever address hits the register window
// R16: with turbo off the arrays go to standby after about 70ns idle inputs
// R17: clearing power register one bit 3 turns turbo off
// R18: five power register three bits block strobes from the arrays; bit 4 is stored but has no strobe to block
// R19: general logic yields two external chip selects
// R20: secondary sector wins over overlapping primary sector
// R21: SRAM, register or peripheral targets win over overlapping flash
// R22: mapping has a configured reset value and stays writable
// R23: a memory is selected only if decoded and its strobe is permitted
// R24: reset clears page and returns mapping to its configured value
module msd_decode #(
    parameter int VEC_W = 64,
    parameter logic [7:0] SPACE_INIT = `MSD_RST_SPACE
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // core bus
    input msd_pkg::msd_bus_s bus,
    input wire logic [7:0] wdata,
    // other decode inputs
    input wire logic power_down,
    input wire logic [21:0] port_in,
    input wire logic [15:0] mcell_fb,
    input wire logic flash_ready,
    // programmed decode equations
    input wire logic [13*2*VEC_W-1:0] sel_care,
    input wire logic [13*2*VEC_W-1:0] sel_match,
    input wire logic [13*2-1:0] sel_en,
    input wire logic [3*VEC_W-1:0] ecs_care,
    input wire logic [3*VEC_W-1:0] ecs_match,
    input wire logic [1:0] ecs_en,
    // outputs
    output logic [7:0] rdata,
    output msd_pkg::msd_sel_s sel,
    output logic [1:0] external_chip_selects,
    output logic [7:0] page_bits,
    output logic logic_standby
);
    // the decode vector layout below is fixed at 64 inputs
    if (VEC_W != 64) begin : g_bad_width
        $error("msd_decode: VEC_W must be 64");
    end

    // pins come from outside the clock domain: two stages before use
    msd_pkg::msd_bus_s bus_m_q, bus_s_q;
    logic [39:0] misc_m_q, misc_s_q;
    // write data takes the same two stages as the strobe so both line up
    logic [7:0] wdata_m_q, wdata_s_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_m_q <= '{16'h0000, 1'b1, 1'b1, 1'b1, 1'b0};
            bus_s_q <= '{16'h0000, 1'b1, 1'b1, 1'b1, 1'b0};
            misc_m_q <= 40'h00_0000_0000;
            misc_s_q <= 40'h00_0000_0000;
            wdata_m_q <= 8'h00;
            wdata_s_q <= 8'h00;
        end else begin
            bus_m_q <= bus;
            bus_s_q <= bus_m_q;
            misc_m_q <= {power_down, flash_ready, mcell_fb, port_in};
            misc_s_q <= misc_m_q;
            wdata_m_q <= wdata;
            wdata_s_q <= wdata_m_q;
        end
    end

    logic [7:0] space_mapping_q, page_extension_q, pwr0_q, pwr2_q;
    logic wr_d1_q;
    logic reg_hit;
    logic [7:0] off;
    // see R15
    assign reg_hit = (bus_s_q.addr & `MSD_WIN_MASK) == `MSD_WIN_BASE;
    assign off = bus_s_q.addr[7:0];

    // write taken on the falling edge of the write strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_d1_q <= 1'b0;
        end else begin
            wr_d1_q <= !bus_s_q.wr_n;
        end
    end

    // see R6 / R7 / R22 / R24; mapping stays writable at run time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_extension_q <= `MSD_RST_PAGE;
            space_mapping_q <= SPACE_INIT;
            pwr0_q <= `MSD_RST_PWR0;
            pwr2_q <= `MSD_RST_PWR2;
        end else if (!bus_s_q.wr_n && !wr_d1_q && reg_hit) begin
            if (off == `MSD_OFF_PAGE) begin
                page_extension_q <= wdata_s_q;
            end else if (off == `MSD_OFF_SPACE) begin
                space_mapping_q <= wdata_s_q;
            end else if (off == `MSD_OFF_PWR0) begin
                pwr0_q <= wdata_s_q;
            end else if (off == `MSD_OFF_PWR2) begin
                pwr2_q <= {3'b000, wdata_s_q[4:0]};
            end
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (reg_hit && !bus_s_q.rd_n) begin
            if (off == `MSD_OFF_PAGE) begin
                rdata <= page_extension_q; // see R6
            end else if (off == `MSD_OFF_SPACE) begin
                rdata <= space_mapping_q;
            end else if (off == `MSD_OFF_PWR0) begin
                rdata <= pwr0_q;
            end else if (off == `MSD_OFF_PWR2) begin
                rdata <= pwr2_q;
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // strobes seen by the arrays, each gated by power register three
    // blocking a strobe used by an equation makes that equation misfire
    logic [4:0] strobe_act;
    always_comb begin
        strobe_act = {1'b0, !bus_s_q.fetch_n, !bus_s_q.rd_n, !bus_s_q.wr_n, bus_s_q.ale};
        strobe_act = strobe_act & ~pwr2_q[4:0]; // see R18
    end

    // decode vector: address, strobes, reset, power-down, ports, page, ready, feedback
    logic [VEC_W-1:0] vec;
    // see R10 / R8
    assign vec = {bus_s_q.addr, strobe_act[3:0], rst, misc_s_q[39], misc_s_q[21:0],
                  page_extension_q, misc_s_q[38], misc_s_q[37:28], 1'b0};

    logic [12:0] raw;
    logic [1:0] external_chip_selects_d;
    genvar g;
    generate
        for (g = 0; g < 13; g++) begin : g_sel
            // see R11 / R12 / R13
            msd_term #(.IN_W(VEC_W), .TERMS(g == 12 ? 2 : 3)) u_term (
                .vec(vec),
                .care(sel_care[g*2*VEC_W +: (g == 12 ? 2 : 3)*VEC_W]),
                .match(sel_match[g*2*VEC_W +: (g == 12 ? 2 : 3)*VEC_W]),
                .term_en(sel_en[g*2 +: (g == 12 ? 2 : 3)]),
                .hit(raw[g])
            );
        end
        for (g = 0; g < 2; g++) begin : g_ecs
            // see R19
            msd_term #(.IN_W(VEC_W), .TERMS(2)) u_ecs (
                .vec(vec),
                .care(ecs_care[g*VEC_W +: 2*VEC_W]),
                .match(ecs_match[g*VEC_W +: 2*VEC_W]),
                .term_en({1'b0, ecs_en[g]}),
                .hit(external_chip_selects_d[g])
            );
        end
    endgenerate

    // strobe permission and priority
    logic rd_cyc, ps_cyc, pio, hi_pri;
    msd_pkg::msd_sel_s sel_d;
    assign rd_cyc = strobe_act[2];
    assign ps_cyc = strobe_act[3];
    assign pio = space_mapping_q[`MSD_BIT_PIO]; // see R3
    // a flash answers only to a strobe that its mapping bit lets through; SRAM reads always pass
    function automatic logic strobe_ok(input logic rd, input logic ps, input logic rd_ok,
                                       input logic ps_ok);
        return (rd && rd_ok) || (ps && ps_ok);
    endfunction

    always_comb begin
        sel_d = '0;
        // see R1 / R5 / R23
        sel_d.ram = raw[12] && strobe_ok(rd_cyc, ps_cyc, 1'b1, space_mapping_q[`MSD_BIT_PS_RAM]);
        sel_d.regs = reg_hit; // see R14
        sel_d.periph = pio ? {2{reg_hit && off[7]}} & {off[0], !off[0]} : 2'b00;
        hi_pri = sel_d.ram || sel_d.regs || (sel_d.periph != 2'b00);
        // see R2
        sel_d.secondary = raw[11:8] & {4{strobe_ok(rd_cyc, ps_cyc,
            space_mapping_q[`MSD_BIT_RD_SEC], space_mapping_q[`MSD_BIT_PS_SEC])}};
        sel_d.primary = raw[7:0] & {8{strobe_ok(rd_cyc, ps_cyc,
            space_mapping_q[`MSD_BIT_RD_PRI], space_mapping_q[`MSD_BIT_PS_PRI])}};
        if (sel_d.secondary != 4'h0) begin
            sel_d.primary = 8'h00; // see R20
        end
        if (hi_pri) begin
            sel_d.primary = 8'h00; // see R21
            sel_d.secondary = 4'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel <= '0;
            external_chip_selects <= 2'b00;
            page_bits <= 8'h00;
        end else begin
            sel <= sel_d;
            external_chip_selects <= external_chip_selects_d;
            page_bits <= page_extension_q; // see R9
        end
    end

    // standby only when turbo is off
    msd_pkg::msd_pwr_e pwr_state;
    msd_idle #(.IN_W(VEC_W), .CYC(`MSD_IDLE_CYC)) u_idle (
        .clk(clk),
        .rst(rst),
        .vec(vec),
        .allow(!pwr0_q[`MSD_BIT_TURBO]), // see R17
        .state(pwr_state)
    );
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            logic_standby <= 1'b0;
        end else begin
            logic_standby <= pwr_state == msd_pkg::MSD_STANDBY; // see R16
        end
    end

    // assertions
    secondary_read_gate_a: assert property (@(posedge clk) disable iff (rst) // see R2
        (rd_cyc && !ps_cyc && !space_mapping_q[`MSD_BIT_RD_SEC]) |=> sel.secondary == 4'h0)
        else $error("secondary flash selected on blocked read");
    secondary_over_primary_a: assert property (@(posedge clk) disable iff (rst) // see R20
        (sel.secondary != 4'h0) |-> sel.primary == 8'h00)
        else $error("primary selected alongside secondary");
    ram_over_flash_a: assert property (@(posedge clk) disable iff (rst) // see R21
        sel.ram |-> (sel.primary == 8'h00 && sel.secondary == 4'h0))
        else $error("flash selected alongside sram");
    regblock_window_a: assert property (@(posedge clk) disable iff (rst) // see R15
        reg_hit |=> sel.regs)
        else $error("register block select missed");
    page_write_a: assert property (@(posedge clk) disable iff (rst) // see R6
        (!bus_s_q.wr_n && !wr_d1_q && reg_hit && off == `MSD_OFF_PAGE)
        |=> page_extension_q == $past(wdata_s_q))
        else $error("page register did not load");
    page_export_a: assert property (@(posedge clk) disable iff (rst) // see R9
        ##1 page_bits == $past(page_extension_q))
        else $error("page bits not exported");
    periph_mode_a: assert property (@(posedge clk) disable iff (rst) // see R3
        !pio |=> sel.periph == 2'b00)
        else $error("peripheral select outside pio mode");
    turbo_on_a: assert property (@(posedge clk) disable iff (rst) // see R17
        pwr0_q[`MSD_BIT_TURBO] [*3] |-> !logic_standby)
        else $error("standby while turbo on");

    // per-strobe permission checks, then register, select and turbo checks; a lone strobe keeps the other path out of the picture
    primary_read_gate_a: assert property (@(posedge clk) disable iff (rst) // see R1
        (rd_cyc && !ps_cyc && !space_mapping_q[`MSD_BIT_RD_PRI]) |=> sel.primary == 8'h00)
        else $error("primary flash selected on blocked read");
    primary_fetch_gate_a: assert property (@(posedge clk) disable iff (rst) // see R5
        (ps_cyc && !rd_cyc && !space_mapping_q[`MSD_BIT_PS_PRI]) |=> sel.primary == 8'h00)
        else $error("primary flash selected on blocked fetch");
    secondary_fetch_gate_a: assert property (@(posedge clk) disable iff (rst) // see R1
        (ps_cyc && !rd_cyc && !space_mapping_q[`MSD_BIT_PS_SEC]) |=> sel.secondary == 4'h0)
        else $error("secondary flash selected on blocked fetch");
    ram_fetch_gate_a: assert property (@(posedge clk) disable iff (rst) // see R23
        (ps_cyc && !rd_cyc && !space_mapping_q[`MSD_BIT_PS_RAM]) |=> !sel.ram)
        else $error("sram selected on blocked fetch");
    strobe_block_a: assert property (@(posedge clk) disable iff (rst) // see R18
        (pwr2_q[2] && !ps_cyc) |=> (sel.primary == 8'h00 && sel.secondary == 4'h0 && !sel.ram))
        else $error("blocked read strobe still selected a memory");
    page_read_a: assert property (@(posedge clk) disable iff (rst) // see R7
        (reg_hit && !bus_s_q.rd_n && off == `MSD_OFF_PAGE) |=> rdata == $past(page_extension_q))
        else $error("page register read back wrong");
    regs_outside_a: assert property (@(posedge clk) disable iff (rst) // see R15
        !reg_hit |=> !sel.regs)
        else $error("register block selected outside its window");
    periph_select_a: assert property (@(posedge clk) disable iff (rst) // see R14
        (pio && reg_hit && off[7]) |=> sel.periph != 2'b00)
        else $error("peripheral select missed in pio mode");
    space_write_a: assert property (@(posedge clk) disable iff (rst) // see R22
        (!bus_s_q.wr_n && !wr_d1_q && reg_hit && off == `MSD_OFF_SPACE)
        |=> space_mapping_q == $past(wdata_s_q))
        else $error("mapping register did not load");
    turbo_wake_a: assert property (@(posedge clk) disable iff (rst) // see R17
        pwr0_q[`MSD_BIT_TURBO] |-> ##2 !logic_standby)
        else $error("standby kept after turbo set");
endmodule

// File: verification/msd_cpu.sv
// core-side bus model that runs register writes and fetch or read cycles
`timescale 1ns/1ns
`include "msd_map.svh"
module msd_cpu (
    // clock
    input wire logic clk,
    // core bus
    output msd_pkg::msd_bus_s bus,
    output logic [7:0] wdata
);
    initial begin
        bus = '{16'h0000, 1'b1, 1'b1, 1'b1, 1'b0};
        wdata = 8'h00;
    end
    // every change lands one ns after the edge so the design samples settled pins
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // address phase: latch pulse first, strobes stay high meanwhile
    task automatic addr_phase(input logic [15:0] a);
        bus.addr = a;
        bus.ale = 1'b1;
        wait_cyc(1);
        bus.ale = 1'b0;
    endtask
    // one write per strobe pulse, data held past the rising strobe
    task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
        addr_phase({8'hFF, off});
        wdata = d;
        bus.wr_n = 1'b0;
        wait_cyc(4);
        bus.wr_n = 1'b1;
        wait_cyc(1);
        wdata = ~d;
        wait_cyc(1);
    endtask
    // software setup for split program and data spaces
    task automatic load_separate();
        write_reg(`MSD_OFF_SPACE, 8'h0C);
    endtask
    // strobe is left low so the caller can look at the answer
    task automatic start(input logic [15:0] a, input logic fetch);
        addr_phase(a);
        bus.fetch_n = !fetch;
        bus.rd_n = fetch;
        wait_cyc(5);
    endtask
    task automatic finish();
        bus.fetch_n = 1'b1;
        bus.rd_n = 1'b1;
        wait_cyc(2);
    endtask
endmodule

// File: verification/test_msd_decode.sv
// self-checking bench for the memory-space decoder
`timescale 1ns/1ns
`include "msd_map.svh"
module test_msd_decode;
    logic clk;
    logic rst;
    msd_pkg::msd_bus_s bus;
    logic [7:0] wdata;
    logic [1663:0] sel_care;
    logic [1663:0] sel_match;
    logic [25:0] sel_en;
    logic [191:0] ecs_care;
    logic [191:0] ecs_match;
    logic [1:0] ecs_en;
    logic [21:0] port_in;
    logic [15:0] mcell_fb;
    logic [7:0] rdata;
    msd_pkg::msd_sel_s sel;
    logic [1:0] ecs;
    logic [7:0] page_bits;
    logic standby;
    int fails = 0;
    int tests_run = 0;
    msd_decode msd_decode_inst (
        .clk(clk), .rst(rst), .bus(bus), .wdata(wdata), .power_down(1'b0),
        .port_in(port_in), .mcell_fb(mcell_fb), .flash_ready(1'b1),
        .sel_care(sel_care), .sel_match(sel_match), .sel_en(sel_en),
        .ecs_care(ecs_care), .ecs_match(ecs_match), .ecs_en(ecs_en),
        .rdata(rdata), .sel(sel), .external_chip_selects(ecs),
        .page_bits(page_bits), .logic_standby(standby)
    );
    msd_cpu msd_cpu_inst (.clk(clk), .bus(bus), .wdata(wdata));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
        msd_cpu_inst.start({8'hFF, off}, 1'b0);
        check("rdata", {8'h00, rdata}, {8'h00, exp});
        msd_cpu_inst.finish();
    endtask
    task automatic sel_chk(input logic [15:0] a, input logic f, input logic [15:0] exp);
        msd_cpu_inst.start(a, f);
        check("sel", sel, exp);
        msd_cpu_inst.finish();
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        msd_cpu_inst.write_reg(off, d);
    endtask
    task automatic scen_regs();
        check("page_bits", {8'h00, page_bits}, 16'h0000);
        rd_chk(`MSD_OFF_PAGE, 8'h00);
        rd_chk(`MSD_OFF_SPACE, `MSD_RST_SPACE);
        rd_chk(`MSD_OFF_PWR0, `MSD_RST_PWR0);
        rd_chk(`MSD_OFF_PWR2, `MSD_RST_PWR2);
        // unmapped offset must swallow writes
        wr(8'h10, 8'h5A);
        rd_chk(8'h10, 8'h00);
        wr(`MSD_OFF_PAGE, 8'hA5);
        check("page_bits", {8'h00, page_bits}, 16'h00A5);
        rd_chk(`MSD_OFF_PAGE, 8'hA5);
        wr(`MSD_OFF_PAGE, 8'h5A);
        rd_chk(`MSD_OFF_PAGE, 8'h5A);
        wr(`MSD_OFF_PWR2, 8'hFF);
        rd_chk(`MSD_OFF_PWR2, 8'h1F);
        wr(`MSD_OFF_PWR2, 8'h00);
        msd_cpu_inst.load_separate();
        rd_chk(`MSD_OFF_SPACE, 8'h0C);
    endtask
    task automatic scen_gating();
        logic [7:0] maps [6];
        logic [25:0] ens [3];
        int pos [3];
        logic hit;
        maps = '{8'h00, 8'h0C, 8'h14, 8'h1F, 8'h6A, 8'h01};
        ens = '{26'h0000002, 26'h0020000, 26'h2000000};
        pos = '{8, 4, 3};
        foreach (maps[m]) begin
            // masked terms must ignore match bits and unused inputs
            sel_match = {1664{m[0]}};
            ecs_match = {192{m[0]}};
            mcell_fb = {16{m[0]}};
            wr(`MSD_OFF_SPACE, maps[m]);
            for (int t = 0; t < 3; t++) begin
                sel_en = ens[t];
                for (int f = 0; f < 2; f++) begin
                    hit = f ? maps[m][2 - t] : (t == 2 || maps[m][4 - t]);
                    sel_chk(16'h1234, f[0], 16'(hit) << pos[t]);
                end
            end
        end
    endtask
    task automatic scen_priority();
        wr(`MSD_OFF_SPACE, 8'h1F);
        sel_en = 26'h2020002;
        sel_chk(16'h1234, 1'b0, 16'h0008);
        sel_en = 26'h0020002;
        sel_chk(16'h1234, 1'b0, 16'h0010);
        sel_chk(16'hFF10, 1'b0, 16'h0004);
        for (int p = 0; p < 3; p++) begin
            wr(`MSD_OFF_SPACE, p == 2 ? 8'h1F : 8'h9F);
            msd_cpu_inst.start(16'hFF80 + 16'(p & 1), 1'b0);
            check("periph", {14'h0, sel.periph}, 16'(p == 2 ? 0 : 1 << p));
            msd_cpu_inst.finish();
        end
        for (int e = 1; e < 3; e++) begin
            ecs_en = 2'(e);
            msd_cpu_inst.wait_cyc(5);
            check("ecs", {14'h0, ecs}, 16'(e));
        end
        wr(`MSD_OFF_PWR2, 8'h04);
        sel_chk(16'h1234, 1'b0, 16'h0000);
        sel_chk(16'h1234, 1'b1, 16'h0010);
        wr(`MSD_OFF_PWR2, `MSD_RST_PWR2);
    endtask
    task automatic scen_standby();
        msd_cpu_inst.wait_cyc(15);
        check("standby", {15'h0, standby}, 16'h0000);
        wr(`MSD_OFF_PWR0, 8'h00);
        msd_cpu_inst.wait_cyc(`MSD_IDLE_CYC + 10);
        check("standby", {15'h0, standby}, 16'h0001);
        port_in = 22'h3FFFFF;
        msd_cpu_inst.wait_cyc(5);
        check("standby", {15'h0, standby}, 16'h0000);
        wr(`MSD_OFF_PWR0, `MSD_RST_PWR0);
    endtask
    task automatic scen_reset();
        wr(`MSD_OFF_PAGE, 8'h3C);
        wr(`MSD_OFF_SPACE, 8'h9F);
        rst = 1'b1;
        msd_cpu_inst.wait_cyc(3);
        rst = 1'b0;
        check("page_bits", {8'h00, page_bits}, 16'h0000);
        rd_chk(`MSD_OFF_PAGE, `MSD_RST_PAGE);
        rd_chk(`MSD_OFF_SPACE, `MSD_RST_SPACE);
    endtask
    task automatic stop_test();
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        sel_care = '0;
        sel_match = '0;
        sel_en = '0;
        ecs_care = '0;
        ecs_match = '0;
        ecs_en = 2'h0;
        port_in = 22'h000000;
        mcell_fb = 16'h0000;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        scen_regs();
        scen_gating();
        scen_priority();
        scen_standby();
        scen_reset();
        stop_test();
    end
    // the full sequence needs well under a tenth of this span
    initial begin
        #200000;
        fails++;
        stop_test();
    end
endmodule
